/* include/rfh_pkg.sv */
package rfh_pkg;
   localparam int RFH_BUF_DEPTH = 128;
   // Register map, six-bit SPI address space
   localparam logic [5:0] RFH_STROBE_MAX = 6'h0E;
   localparam logic [5:0] RFH_ADDR_PIN_CFG0 = 6'h1C;
   localparam logic [5:0] RFH_ADDR_PIN_CFG1 = 6'h1D;
   localparam logic [5:0] RFH_ADDR_SEC_CTRL0 = 6'h19;
   localparam logic [5:0] RFH_ADDR_TX_BUF = 6'h3E;
   localparam logic [5:0] RFH_ADDR_RX_BUF = 6'h3F;
   // Command strobe codes
   localparam logic [5:0] RFH_CMD_XOSC_ON = 6'h01;
   localparam logic [5:0] RFH_CMD_XOSC_OFF = 6'h07;
   localparam logic [5:0] RFH_CMD_FLUSH_RX = 6'h08;
   localparam logic [5:0] RFH_CMD_FLUSH_TX = 6'h09;
   // Header byte fields
   localparam int RFH_HDR_RAM_BIT = 7;
   localparam int RFH_HDR_RD_BIT = 6;
   // Pin configuration 0 fields
   localparam int RFH_CFG0_THR_MSB = 6;
   localparam int RFH_CFG0_CCA_POL = 7;
   localparam int RFH_CFG0_FIFO_POL = 8;
   localparam int RFH_CFG0_DELIM_POL = 9;
   localparam int RFH_CFG0_THR_POL = 10;
   localparam int RFH_CFG0_SO_PULLUP = 11;
   // Pin configuration 1 fields
   localparam int RFH_CFG1_CCA_SEL_LSB = 0;
   localparam int RFH_CFG1_DELIM_SEL_LSB = 5;
   // Security control 0 field
   localparam int RFH_SEC_GUARD_BIT = 9;
   // Status byte fields
   localparam int RFH_ST_XOSC = 6;
   localparam int RFH_ST_UNDERRUN = 5;
   // Reset values
   localparam logic [15:0] RFH_CFG0_RST = 16'h0040;
   localparam logic [15:0] RFH_CFG1_RST = 16'h0000;
   localparam logic [15:0] RFH_SEC0_RST = 16'h0000;

   typedef enum logic [2:0] {
      RFH_EV_NONE = 3'h0,
      RFH_EV_STROBE = 3'h1,
      RFH_EV_REG_WR = 3'h2,
      RFH_EV_TX_WR = 3'h3,
      RFH_EV_RX_WR = 3'h4,
      RFH_EV_RX_RD = 3'h5
   } rfh_ev_kind_t;

   // Parse states, Gray along address, register, buffer
   typedef enum logic [2:0] {
      RFH_ST_ADDR = 3'b000,
      RFH_ST_REG_HI = 3'b001,
      RFH_ST_REG_LO = 3'b011,
      RFH_ST_TXW = 3'b010,
      RFH_ST_RXA = 3'b110,
      RFH_ST_SKIP = 3'b111
   } rfh_spi_state_t;

   typedef struct packed {
      rfh_ev_kind_t kind;
      logic [5:0] addr;
      logic [15:0] data;
   } rfh_evt_t;

   typedef struct packed {
      logic fifo;
      logic thr;
      logic delim;
      logic cca;
   } rfh_pins_t;
endpackage

/* rtl/rfh_buffer_if.sv */
`timescale 1ns/1ns
`default_nettype none
module rfh_buffer_if
   import rfh_pkg::*;
#(
   parameter int DEPTH = RFH_BUF_DEPTH
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic sclk_i,
   input wire logic chip_select_n_i,
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o,
   output logic so_pullup_o,
   input wire logic xosc_stable_i,
   output logic xosc_en_o,
   input wire logic [3:0] status_ext_i,
   input wire logic tx_rd_i,
   output logic [7:0] tx_data_o,
   input wire logic tx_sfd_sent_i,
   input wire logic tx_byte_sent_i,
   input wire logic rx_wr_valid_i,
   input wire logic [7:0] rx_wr_data_i,
   input wire logic rx_sfd_i,
   input wire logic rx_addr_fail_i,
   input wire logic rx_sec_frame_i,
   input wire logic decrypt_done_i,
   input wire logic cca_i,
   output rfh_pins_t pins_o
);
   localparam int AW = $clog2(DEPTH);

   // Pointer logic and 7-bit threshold serve power-of-two depths up to 128
   initial begin
      if (DEPTH < 16 || DEPTH > 128 || (1 << AW) != DEPTH) begin
         $error("rfh_buffer_if: DEPTH must be a power of two from 16 to 128");
      end
   end

   // Register read mux, used by the link side
   function automatic logic [15:0] reg_rd(input logic [5:0] a, input logic [15:0] c0,
                                          input logic [15:0] c1, input logic [15:0] s0);
      reg_rd = 16'h0000;
      if (a == RFH_ADDR_PIN_CFG0) reg_rd = c0;
      if (a == RFH_ADDR_PIN_CFG1) reg_rd = c1;
      if (a == RFH_ADDR_SEC_CTRL0) reg_rd = s0;
   endfunction

   // Debug select: code zero keeps normal function
   function automatic logic pin_pick(input logic [4:0] sel, input logic normal, input logic [7:0] dbg);
      pin_pick = (sel == 5'h00) ? normal : dbg[sel[2:0]];
   endfunction

   // Core-side state read quasi-statically by the link side
   logic [15:0] cfg0_reg, cfg1_reg, sec0_reg;
   logic [7:0] status_reg;
   logic [7:0] rx_head_reg;

   // ---------------- Link domain (serial clock) ----------------
   logic spi_rst_n;
   logic [2:0] bit_cnt_reg;
   logic [6:0] sh_reg;
   rfh_spi_state_t st_reg, st_next;
   logic [6:0] hdr_reg;
   logic [7:0] hi_reg;
   logic [7:0] so_hold_reg;
   logic so_reg;
   rfh_evt_t evt_reg, evt_next;
   logic evt_tgl_reg;

   // Deselect clears the parser so every select opens with an address
   assign spi_rst_n = nrst_i & ~chip_select_n_i;

   wire [7:0] byte_in = {sh_reg, si_i};
   wire byte_done = (bit_cnt_reg == 3'h7);
   wire [5:0] in_addr = byte_in[5:0];
   wire hdr_rd = hdr_reg[RFH_HDR_RD_BIT];
   wire [15:0] reg_val = reg_rd(hdr_reg[5:0], cfg0_reg, cfg1_reg, sec0_reg);

   // Next parse state and event at a byte boundary
   always_comb begin
      st_next = st_reg;
      evt_next = '{kind: RFH_EV_NONE, addr: hdr_reg[5:0], data: {8'h00, byte_in}};
      unique case (st_reg)
         RFH_ST_ADDR: begin
            evt_next.addr = in_addr;
            if (byte_in[RFH_HDR_RAM_BIT]) begin
               st_next = RFH_ST_SKIP; // RAM path lies outside, ends the select
            end else if (in_addr <= RFH_STROBE_MAX) begin
               evt_next.kind = RFH_EV_STROBE;
            end else if (in_addr == RFH_ADDR_TX_BUF) begin
               st_next = byte_in[RFH_HDR_RD_BIT] ? RFH_ST_SKIP : RFH_ST_TXW;
            end else if (in_addr == RFH_ADDR_RX_BUF) begin
               st_next = RFH_ST_RXA;
            end else begin
               st_next = RFH_ST_REG_HI;
            end
         end
         RFH_ST_REG_HI: st_next = RFH_ST_REG_LO;
         RFH_ST_REG_LO: begin
            st_next = RFH_ST_ADDR;
            evt_next.kind = hdr_rd ? RFH_EV_NONE : RFH_EV_REG_WR;
            evt_next.data = {hi_reg, byte_in};
         end
         RFH_ST_TXW: evt_next.kind = RFH_EV_TX_WR;
         RFH_ST_RXA: evt_next.kind = hdr_rd ? RFH_EV_RX_RD : RFH_EV_RX_WR;
         RFH_ST_SKIP: st_next = RFH_ST_SKIP;
      endcase
   end

   // Input shifter and parser, sampled on rising serial clock
   always_ff @(posedge sclk_i or negedge spi_rst_n) begin
      if (!spi_rst_n) begin
         bit_cnt_reg <= 3'h0;
         sh_reg <= 7'h00;
         st_reg <= RFH_ST_ADDR;
         hdr_reg <= 7'h00;
         hi_reg <= 8'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         sh_reg <= byte_in[6:0];
         if (byte_done) begin
            st_reg <= st_next;
            if (st_reg == RFH_ST_ADDR) hdr_reg <= byte_in[6:0];
            if (st_reg == RFH_ST_REG_HI) hi_reg <= byte_in;
         end
      end
   end

   // Event record and toggle survive deselect so no false event appears
   always_ff @(posedge sclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         evt_reg <= '{kind: RFH_EV_NONE, addr: 6'h00, data: 16'h0000};
         evt_tgl_reg <= 1'b0;
      end else if (!chip_select_n_i && byte_done && evt_next.kind != RFH_EV_NONE) begin
         evt_reg <= evt_next;
         evt_tgl_reg <= ~evt_tgl_reg;
      end
   end

   // Outgoing byte source for the next byte, picked by the new state
   wire [7:0] out_src = (st_reg == RFH_ST_REG_HI) ? reg_val[15:8] :
                        (st_reg == RFH_ST_REG_LO) ? reg_val[7:0] :
                        (st_reg == RFH_ST_RXA) ? rx_head_reg :
                        (st_reg == RFH_ST_SKIP) ? 8'h00 : status_reg;
   wire [7:0] out_cur = (st_reg == RFH_ST_ADDR) ? status_reg : so_hold_reg;

   // Serial out changes on falling edge; reset value is status bit 7
   always_ff @(negedge sclk_i or negedge spi_rst_n) begin
      if (!spi_rst_n) begin
         so_reg <= 1'b0;
         so_hold_reg <= 8'h00;
      end else if (bit_cnt_reg == 3'h0) begin
         so_hold_reg <= out_src;
         so_reg <= out_src[7];
      end else begin
         so_reg <= out_cur[~bit_cnt_reg];
      end
   end
   assign so_o = so_reg;

   // ---------------- Core domain ----------------
   logic tgl_s1_reg, tgl_s2_reg, ack_reg;
   logic cs_s1_reg, cs_s2_reg;
   logic so_oe_reg, pullup_reg, xosc_en_reg;

   // Event toggle and chip select pass two flops
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
      end else begin
         tgl_s1_reg <= evt_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         cs_s1_reg <= chip_select_n_i;
         cs_s2_reg <= cs_s1_reg;
      end
   end

   // A host receive write waits while the radio writes
   wire ev_pend = (tgl_s2_reg != ack_reg);
   wire ev_go = ev_pend && !(rx_wr_valid_i && evt_reg.kind == RFH_EV_RX_WR);
   wire strobe = ev_go && evt_reg.kind == RFH_EV_STROBE;
   wire strobe_ok = strobe && (xosc_stable_i || evt_reg.addr == RFH_CMD_XOSC_ON);
   wire flush_tx = strobe_ok && evt_reg.addr == RFH_CMD_FLUSH_TX;
   wire flush_rx = strobe_ok && evt_reg.addr == RFH_CMD_FLUSH_RX;
   wire reg_wr = ev_go && evt_reg.kind == RFH_EV_REG_WR;

   // Handshake, strobes, configuration registers, serial-out enables
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_reg <= 1'b0;
         xosc_en_reg <= 1'b0;
         cfg0_reg <= RFH_CFG0_RST;
         cfg1_reg <= RFH_CFG1_RST;
         sec0_reg <= RFH_SEC0_RST;
         so_oe_reg <= 1'b0;
         pullup_reg <= 1'b0;
      end else begin
         if (ev_go) ack_reg <= tgl_s2_reg;
         if (strobe_ok && evt_reg.addr == RFH_CMD_XOSC_ON) xosc_en_reg <= 1'b1;
         if (strobe_ok && evt_reg.addr == RFH_CMD_XOSC_OFF) xosc_en_reg <= 1'b0;
         if (reg_wr && evt_reg.addr == RFH_ADDR_PIN_CFG0) cfg0_reg <= evt_reg.data;
         if (reg_wr && evt_reg.addr == RFH_ADDR_PIN_CFG1) cfg1_reg <= evt_reg.data;
         if (reg_wr && evt_reg.addr == RFH_ADDR_SEC_CTRL0) sec0_reg <= evt_reg.data;
         so_oe_reg <= ~cs_s2_reg;
         pullup_reg <= cfg0_reg[RFH_CFG0_SO_PULLUP];
      end
   end

   // ---- Transmit buffer ----
   logic [7:0] tx_mem [DEPTH];
   logic [AW-1:0] tx_wp_reg, tx_rp_reg;
   logic [AW:0] tx_cnt_reg;
   logic underrun_reg, tx_delim_reg, tx_need_len_reg;
   logic [6:0] tx_left_reg;
   logic [7:0] tx_data_reg;

   wire tx_push = ev_go && evt_reg.kind == RFH_EV_TX_WR && tx_cnt_reg != (AW+1)'(DEPTH);
   wire tx_pop = tx_rd_i && tx_cnt_reg != '0;
   wire tx_under = tx_rd_i && tx_cnt_reg == '0;

   // Transmit store write port
   always_ff @(posedge mclk_i) begin
      if (tx_push) tx_mem[tx_wp_reg] <= evt_reg.data[7:0];
   end

   // Transmit pointers, underrun flag and delimiter pin
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tx_wp_reg <= '0;
         tx_rp_reg <= '0;
         tx_cnt_reg <= '0;
         underrun_reg <= 1'b0;
         tx_delim_reg <= 1'b0;
         tx_need_len_reg <= 1'b0;
         tx_left_reg <= 7'h00;
         tx_data_reg <= 8'h00;
      end else if (flush_tx) begin
         tx_wp_reg <= '0;
         tx_rp_reg <= '0;
         tx_cnt_reg <= '0;
         underrun_reg <= tx_under;
         tx_delim_reg <= 1'b0;
      end else begin
         if (tx_push) tx_wp_reg <= tx_wp_reg + 1'b1;
         if (tx_pop) tx_rp_reg <= tx_rp_reg + 1'b1;
         if (tx_pop) tx_data_reg <= tx_mem[tx_rp_reg];
         tx_cnt_reg <= tx_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
         if (tx_under) underrun_reg <= 1'b1;
         if (tx_sfd_sent_i) begin
            tx_delim_reg <= 1'b1;
            tx_need_len_reg <= 1'b1;
         end else if (tx_under) begin
            tx_delim_reg <= 1'b0;
         end else if (tx_need_len_reg && tx_pop) begin
            tx_need_len_reg <= 1'b0;
            tx_left_reg <= tx_mem[tx_rp_reg][6:0];
         end else if (tx_delim_reg && !tx_need_len_reg && tx_byte_sent_i) begin
            tx_left_reg <= tx_left_reg - 7'h01;
            if (tx_left_reg <= 7'h01) tx_delim_reg <= 1'b0;
         end
      end
   end

   // ---- Receive buffer ----
   logic [7:0] rx_mem [DEPTH];
   logic [AW-1:0] rx_wp_reg, rx_rp_reg, frm_start_reg;
   logic [AW:0] rx_cnt_reg, prot_cnt_reg, frm_bytes_reg;
   logic ovf_reg, rd_since_ovf_reg, thr_hold_reg, cmpl_reg, prot_act_reg;
   logic rx_delim_reg, rx_need_len_reg;
   logic [6:0] rx_len_reg;

   // Guarded header bytes still occupy space after being read
   wire [AW+1:0] occ = (AW+2)'(rx_cnt_reg) + (AW+2)'(prot_cnt_reg);
   wire rx_full = occ >= (AW+2)'(DEPTH);
   wire radio_wr = rx_wr_valid_i && !ovf_reg && !rx_full;
   wire radio_ovf = rx_wr_valid_i && !ovf_reg && rx_full;
   wire host_wr = ev_go && evt_reg.kind == RFH_EV_RX_WR && !rx_full;
   wire host_rd = ev_go && evt_reg.kind == RFH_EV_RX_RD;
   wire rx_pop = host_rd && rx_cnt_reg != '0;
   wire rx_wr = radio_wr || host_wr;
   wire [7:0] rx_wdat = radio_wr ? rx_wr_data_i : evt_reg.data[7:0];
   wire frm_end = radio_wr && rx_delim_reg && !rx_need_len_reg
                  && frm_bytes_reg == (AW+1)'(rx_len_reg);
   wire rx_fail = rx_addr_fail_i && rx_delim_reg;
   wire guard_on = sec0_reg[RFH_SEC_GUARD_BIT];
   wire [AW-1:0] rx_rp_next = rx_rp_reg + AW'(rx_pop);

   // Receive store write port
   always_ff @(posedge mclk_i) begin
      if (rx_wr) rx_mem[rx_wp_reg] <= rx_wdat;
   end

   // Receive pointers, overflow, guard, frame tracking
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_wp_reg <= '0;
         rx_rp_reg <= '0;
         rx_cnt_reg <= '0;
         prot_cnt_reg <= '0;
         frm_start_reg <= '0;
         frm_bytes_reg <= '0;
         ovf_reg <= 1'b0;
         rd_since_ovf_reg <= 1'b0;
         thr_hold_reg <= 1'b0;
         cmpl_reg <= 1'b0;
         prot_act_reg <= 1'b0;
         rx_delim_reg <= 1'b0;
         rx_need_len_reg <= 1'b0;
         rx_len_reg <= 7'h00;
         rx_head_reg <= 8'h00;
      end else if (flush_rx) begin
         rx_wp_reg <= '0;
         rx_rp_reg <= '0;
         rx_cnt_reg <= '0;
         prot_cnt_reg <= '0;
         ovf_reg <= 1'b0;
         thr_hold_reg <= ovf_reg && !rd_since_ovf_reg;
         cmpl_reg <= 1'b0;
         prot_act_reg <= 1'b0;
         rx_delim_reg <= 1'b0;
      end else begin
         if (rx_wr) rx_wp_reg <= rx_wp_reg + 1'b1;
         rx_rp_reg <= rx_rp_next;
         if (rx_fail) begin
            rx_wp_reg <= frm_start_reg;
            rx_cnt_reg <= rx_cnt_reg - frm_bytes_reg - (AW+1)'(rx_pop);
         end else begin
            rx_cnt_reg <= rx_cnt_reg + (AW+1)'(rx_wr) - (AW+1)'(rx_pop);
         end
         if (radio_ovf) begin
            ovf_reg <= 1'b1;
            rd_since_ovf_reg <= 1'b0;
         end else if (host_rd) begin
            rd_since_ovf_reg <= 1'b1;
         end
         if (host_rd) thr_hold_reg <= 1'b0;
         if (frm_end) cmpl_reg <= 1'b1;
         else if (rx_cnt_reg == '0) cmpl_reg <= 1'b0;
         if (decrypt_done_i) begin
            prot_act_reg <= 1'b0;
            prot_cnt_reg <= '0;
         end else begin
            if (rx_sec_frame_i && guard_on) prot_act_reg <= 1'b1;
            if (prot_act_reg && rx_pop) prot_cnt_reg <= prot_cnt_reg + 1'b1;
         end
         if (rx_sfd_i) begin
            rx_delim_reg <= 1'b1;
            rx_need_len_reg <= 1'b1;
            frm_start_reg <= rx_wp_reg;
            frm_bytes_reg <= '0;
         end else if (rx_fail || frm_end) begin
            rx_delim_reg <= 1'b0;
         end else if (radio_wr && rx_delim_reg) begin
            frm_bytes_reg <= frm_bytes_reg + 1'b1;
            if (rx_need_len_reg) rx_len_reg <= rx_wr_data_i[6:0];
            rx_need_len_reg <= 1'b0;
         end
         rx_head_reg <= rx_mem[rx_rp_next];
      end
   end

   // ---- Status byte and pins ----
   logic [7:0] status_next;
   rfh_pins_t pins_reg, pins_norm;
   wire [7:0] dbg_vec = {xosc_stable_i, underrun_reg, ovf_reg, prot_act_reg,
                         cmpl_reg, rx_delim_reg, tx_delim_reg, 1'b0};
   wire [4:0] delim_sel = cfg1_reg[RFH_CFG1_DELIM_SEL_LSB +: 5];
   wire [4:0] cca_sel = cfg1_reg[RFH_CFG1_CCA_SEL_LSB +: 5];
   wire [6:0] thr_lvl = cfg0_reg[RFH_CFG0_THR_MSB:0];

   // Normal pin meanings; fifo and threshold use receive state only
   assign pins_norm.fifo = rx_cnt_reg != '0 && !ovf_reg;
   assign pins_norm.thr = (8'(rx_cnt_reg) > {1'b0, thr_lvl}) || cmpl_reg
                          || ovf_reg || thr_hold_reg;
   assign pins_norm.delim = pin_pick(delim_sel, rx_delim_reg | tx_delim_reg, dbg_vec);
   assign pins_norm.cca = pin_pick(cca_sel, cca_i, dbg_vec);
   assign status_next = {1'b0, xosc_stable_i, underrun_reg, status_ext_i, 1'b0};

   // Registered pins with polarity selection
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pins_reg <= '{fifo: 1'b0, thr: 1'b0, delim: 1'b0, cca: 1'b0};
         status_reg <= 8'h00;
      end else begin
         pins_reg.fifo <= pins_norm.fifo ^ cfg0_reg[RFH_CFG0_FIFO_POL];
         pins_reg.thr <= pins_norm.thr ^ cfg0_reg[RFH_CFG0_THR_POL];
         pins_reg.delim <= pins_norm.delim ^ cfg0_reg[RFH_CFG0_DELIM_POL];
         pins_reg.cca <= pins_norm.cca ^ cfg0_reg[RFH_CFG0_CCA_POL];
         status_reg <= status_next;
      end
   end

   assign pins_o = pins_reg;
   assign so_oe_o = so_oe_reg;
   assign so_pullup_o = pullup_reg;
   assign xosc_en_o = xosc_en_reg;
   assign tx_data_o = tx_data_reg;
endmodule
`default_nettype wire

/* bench/rfh_buffer_if_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// Port-level checks on the buffer host block
module rfh_buffer_if_properties
   import rfh_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic chip_select_n_i,
   input wire logic so_oe_o,
   input wire logic tx_sfd_sent_i,
   input wire logic rx_wr_valid_i,
   input wire logic rx_sfd_i,
   input wire logic rx_addr_fail_i,
   input wire logic decrypt_done_i,
   input wire logic cca_i,
   input wire rfh_pins_t pins_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);
   logic [3:0] quiet_reg;
   wire quiet = quiet_reg == 4'hF;
   // Cycles since deselect; once saturated no register write can still land
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i)
         quiet_reg <= 4'h0;
      else if (!chip_select_n_i)
         quiet_reg <= 4'h0;
      else if (!quiet)
         quiet_reg <= quiet_reg + 4'h1;
   end
   // Select held steady long enough to pass the synchroniser
   sequence desel_4;
      chip_select_n_i [*4];
   endsequence
   sequence sel_4;
      !chip_select_n_i [*4];
   endsequence
   // Receive-side causes two cycles back
   sequence rx_cause;
      $past(rx_wr_valid_i, 2) || $past(rx_addr_fail_i, 2) || $past(decrypt_done_i, 2);
   endsequence
   so_idle_a: assert property (desel_4 |-> !so_oe_o) else $error("serial out driven when idle");
   so_drive_a: assert property (sel_4 |-> so_oe_o) else $error("serial out not driven");
   rx_delim_a: assert property (rx_sfd_i |-> ##2 $changed(pins_o.delim)) else $error("no rx delim edge");
   fail_delim_a: assert property (rx_addr_fail_i |-> ##2 $changed(pins_o.delim)) else $error("no fail edge");
   tx_delim_a: assert property (tx_sfd_sent_i |-> ##2 $changed(pins_o.delim)) else $error("no tx delim edge");
   fifo_cause_a: assert property ($changed(pins_o.fifo) && quiet |-> rx_cause) else $error("fifo pin moved");
   thr_cause_a: assert property ($changed(pins_o.thr) && quiet |-> rx_cause) else $error("thr pin moved");
   cca_follow_a: assert property ($changed(cca_i) && quiet |-> ##[1:2] $changed(pins_o.cca))
      else $error("cca pin stuck");
endmodule
bind rfh_buffer_if rfh_buffer_if_properties chk (.mclk_i, .nrst_i, .chip_select_n_i, .so_oe_o, .tx_sfd_sent_i,
   .rx_wr_valid_i, .rx_sfd_i, .rx_addr_fail_i, .decrypt_done_i, .cca_i, .pins_o);
`default_nettype wire

/* bench/rfh_spi_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Host SPI master; clock idles low outside frames
module rfh_spi_host (
   output logic sclk_o,
   output logic csel_n_o,
   output logic si_o,
   input wire logic so_i
);
   initial begin
      {sclk_o, si_o} = 2'b00;
      csel_n_o = 1'b1;
   end
   // Select, then let the output enable settle
   task automatic sel();
      csel_n_o = 1'b0;
      #500;
   endtask
   // Only a deselect ends a buffer access
   task automatic desel();
      #63;
      csel_n_o = 1'b1;
      si_o = ~si_o;
      #600;
   endtask
   // One byte MSB first, serial out taken at the rise
   task automatic xbyte(input logic [7:0] d, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         si_o = d[i];
         #62 sclk_o = 1'b1;
         r[i] = so_i;
         // Last high phase is stretched so a buffer pop lands before the next byte loads
         #(i == 0 ? 563 : 63) sclk_o = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import rfh_pkg::*;
   logic mclk_i, nrst_i, sclk, csel_n, si, so_o, so_oe_o, so_pullup_o, so_last, zero;
   logic xosc_stable_i, xosc_en_o, cca_i, tx_rd_i, tx_sfd_sent_i, rx_wr_valid_i, rx_sfd_i, rx_addr_fail_i;
   logic [3:0] status_ext_i, pv;
   logic [7:0] tx_data_o, rx_wr_data_i, q;
   logic [7:0] mq[$];
   logic [15:0] w;
   rfh_pins_t pins_o;
   int errors = 0, n_checks = 0, seed = 29, cycles = 0, n;
   // Released serial out: pulled high, else the inverse of the last bit
   wire so_w = so_oe_o ? so_o : (so_pullup_o | ~so_last);
   assign {rx_addr_fail_i, rx_sfd_i, tx_sfd_sent_i, tx_rd_i} = pv;
   always @(so_o or so_oe_o) if (so_oe_o) so_last = so_o;
   rfh_spi_host host (.sclk_o(sclk), .csel_n_o(csel_n), .si_o(si), .so_i(so_w));
   rfh_buffer_if uut (.mclk_i, .nrst_i, .sclk_i(sclk), .chip_select_n_i(csel_n), .si_i(si), .so_o, .so_oe_o,
      .so_pullup_o, .xosc_stable_i, .xosc_en_o, .status_ext_i, .tx_rd_i, .tx_data_o, .tx_sfd_sent_i,
      .tx_byte_sent_i(zero), .rx_wr_valid_i, .rx_wr_data_i, .rx_sfd_i, .rx_addr_fail_i,
      .rx_sec_frame_i(zero), .decrypt_done_i(zero), .cca_i, .pins_o);
   // Core clock and hang guard
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         give_verdict();
      end
   end
   function automatic logic [7:0] exp_st(input logic u);
      return {1'b0, xosc_stable_i, u, status_ext_i, 1'b0};
   endfunction
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(negedge mclk_i);
   endtask
   task automatic pulse(input int k);
      @(negedge mclk_i) pv[k] = 1'b1;
      @(negedge mclk_i) pv[k] = 1'b0;
   endtask
   task automatic rx_put(input logic [7:0] b);
      @(negedge mclk_i) rx_wr_valid_i = 1'b1;
      rx_wr_data_i = b;
      @(negedge mclk_i) rx_wr_valid_i = 1'b0;
   endtask
   // Byte exchange; last two bytes seen build a word
   task automatic xb(input logic [7:0] b);
      host.xbyte(b, q);
      w = {w[7:0], q};
   endtask
   task automatic spi(input logic [7:0] bq[$]);
      host.sel();
      foreach (bq[i]) xb(bq[i]);
      host.desel();
      wt(1);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      {nrst_i, pv, rx_wr_valid_i, zero, so_last, cca_i, rx_wr_data_i} = '0;
      xosc_stable_i = 1'b1;
      status_ext_i = 4'($random(seed));
      wt(4);
      nrst_i = 1'b1;
      wt(3);
      spi('{{2'b00, RFH_CMD_XOSC_ON}});
      chk("status", exp_st(1'b0), q);
      chk("xosc_en", 1'b1, xosc_en_o);
      xosc_stable_i = 1'b0;
      spi('{{2'b00, RFH_CMD_XOSC_OFF}});
      chk("xosc_en", 1'b1, xosc_en_o);
      xosc_stable_i = 1'b1;
      $display("test strobes done");
      wt(16);
      pulse(2);
      rx_put(8'h05);
      rx_put(8'h41);
      pulse(3);
      wt(3);
      chk("pins", 4'h0, pins_o);
      n = 3 + ($random(seed) & 7);
      mq = {8'(n)};
      repeat (n) mq.push_back(8'($random(seed)));
      wt(16);
      pulse(2);
      foreach (mq[i]) rx_put(mq[i]);
      wt(3);
      chk("pins", 4'hC, pins_o);
      host.sel();
      xb({2'b01, RFH_ADDR_RX_BUF});
      foreach (mq[i]) begin
         xb(8'h00);
         chk("rx_byte", mq[i], q);
      end
      host.desel();
      wt(3);
      chk("pins", 4'h0, pins_o);
      $display("test rx frame done");
      n = 4 + ($random(seed) & 3);
      mq = {8'(n - 1)};
      repeat (n - 1) mq.push_back(8'($random(seed)));
      host.sel();
      xb({2'b00, RFH_CMD_FLUSH_TX});
      xb({2'b00, RFH_ADDR_PIN_CFG0});
      xb(RFH_CFG0_RST[15:8]);
      xb(RFH_CFG0_RST[7:0]);
      xb({2'b00, RFH_ADDR_TX_BUF});
      foreach (mq[i]) begin
         xb(mq[i]);
         chk("status", exp_st(1'b0), q);
      end
      host.desel();
      spi('{{2'b01, RFH_ADDR_TX_BUF}, 8'h00});
      chk("tx_read", 8'h00, q);
      pulse(1);
      wt(2);
      chk("delim", 1'b1, pins_o.delim);
      foreach (mq[i]) begin
         pulse(0);
         wt(2);
         chk("tx_byte", mq[i], tx_data_o);
      end
      pulse(0);
      wt(3);
      chk("pins", 4'h0, pins_o);
      spi('{{2'b00, RFH_CMD_FLUSH_TX}});
      chk("status", exp_st(1'b1), q);
      spi('{{2'b00, RFH_CMD_XOSC_ON}});
      chk("status", exp_st(1'b0), q);
      $display("test tx done");
      wt(16);
      pulse(2);
      rx_put(8'h7F);
      repeat (RFH_BUF_DEPTH) rx_put(8'($random(seed)));
      wt(3);
      chk("pins", 4'h4, pins_o);
      spi('{{2'b01, RFH_ADDR_RX_BUF}, 8'h00});
      chk("rx_byte", 8'h7F, q);
      spi('{{2'b00, RFH_CMD_FLUSH_RX}});
      wt(3);
      chk("pins", 4'h0, pins_o);
      $display("test overflow done");
      spi('{{2'b00, RFH_ADDR_PIN_CFG0}, 8'h0F, 8'hC0});
      spi('{{2'b01, RFH_ADDR_PIN_CFG0}, 8'h00, 8'h00});
      chk("cfg0", 16'h0FC0, w);
      chk("pins", 4'hF, pins_o);
      chk("pullup", 1'b1, so_pullup_o);
      spi('{8'h60, 8'h00, 8'h00});
      chk("unmapped", 16'h0000, w);
      wt(16);
      cca_i = 1'b1;
      wt(3);
      chk("pins", 4'hE, pins_o);
      nrst_i = 1'b0;
      wt(2);
      nrst_i = 1'b1;
      wt(3);
      spi('{{2'b01, RFH_ADDR_PIN_CFG0}, 8'h00, 8'h00});
      chk("cfg0", RFH_CFG0_RST, w);
      $display("test registers done");
      give_verdict();
   end
endmodule
`default_nettype wire
